// file: rgei_pkg.sv
package rgei_pkg;
  // host offsets
  localparam logic [7:0] OFS_PIN_LEVEL = 8'h29;
  localparam logic [7:0] OFS_FW_FLAGS = 8'h30;
  localparam logic [7:0] OFS_FW_MASK = 8'h31;
  localparam logic [7:0] OFS_PWR_LOSS = 8'h32;
  localparam logic [7:0] OFS_COVER = 8'h34;
  // field positions
  localparam int LAST_SUPPLY_BIT = 7;
  localparam int COVER_EVENT_BIT = 0;
  localparam int COVER_LEVEL_BIT = 1;
  localparam int PIN_LEVEL_BIT = 0;
  // reset values
  localparam logic [7:0] FW_FLAGS_RST = 8'h00;
  localparam logic [7:0] FW_MASK_RST = 8'h00;
  localparam logic LAST_SUPPLY_RST = 1'b0;
  localparam logic COVER_EVENT_RST = 1'b1;
  // pin select map
  localparam logic [5:0] SEL_HOLE = 6'h1F;
  localparam logic [5:0] SEL_LAST = 6'h39;
  localparam int PIN_SPACE = 64;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rgei_host_req_t;

  typedef struct packed {
    logic pme_fw_event;
    logic smi_fw_event;
    logic pme_intrusion;
    logic smi_intrusion;
  } rgei_event_t;
endpackage

// file: rgei_sync2.sv
`timescale 1ns/1ps
module rgei_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // data
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_reg;

  // first stage is read only by the second stage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_o <= '0;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule // rgei_sync2

// file: rgei_runtime_regs.sv
`timescale 1ns/1ps
module rgei_runtime_regs #(
  parameter int PIN_COUNT = rgei_pkg::PIN_SPACE
) (
  // clock and resets
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic battery_por_i,
  // host register port
  input wire rgei_pkg::rgei_host_req_t host_req_i,
  output logic [7:0] host_rdata_o,
  // embedded controller side
  input wire logic [5:0] pin_select_i,
  input wire logic [7:0] ec_fw_set_i,
  input wire logic ec_clear_block_i,
  input wire logic [PIN_COUNT-1:0] gpio_level_i,
  input wire logic [PIN_COUNT-1:0] gpio_read_en_i,
  // power and cover pins
  input wire logic supply_good_in_i,
  input wire logic sleep_s3_n_i,
  input wire logic cover_switch_i,
  // PME and SMI status and enables
  input wire logic pme_intr_en_i,
  input wire logic smi_intr_en_i,
  output rgei_pkg::rgei_event_t event_status_o,
  output logic pme_event_o,
  output logic smi_event_o
);
  logic [PIN_COUNT-1:0] gpio_sync;
  logic [2:0] misc_sync;
  logic supply_good_s, sleep_s3_n_s, cover_s;
  logic supply_good_d_reg, cover_d_reg, cover_armed_reg;
  logic [1:0] cover_warm_reg;
  logic [7:0] fw_flags_reg, fw_flags_next;
  logic [7:0] fw_mask_reg;
  logic last_supply_state_reg;
  logic cover_event_reg;
  logic intr_sts_reg, intr_clr_pend_reg;
  logic pme_en_d_reg, smi_en_d_reg;
  logic [5:0] pin_index;
  logic pin_valid;
  logic wr_fw_flags, wr_fw_mask, wr_cover;
  logic cover_change;
  logic fw_summary;

  // pins cross into the core clock before any logic sees them
  rgei_sync2 #(.WIDTH(PIN_COUNT)) u_gpio_sync (
    .clk_i(core_clk_i),
    .rst_i(sys_rst_i),
    .d_i(gpio_level_i),
    .q_o(gpio_sync)
  );

  // battery reset only: a system reset must not fake edges on the battery-side latches
  rgei_sync2 #(.WIDTH(3)) u_misc_sync (
    .clk_i(core_clk_i),
    .rst_i(battery_por_i),
    .d_i({supply_good_in_i, sleep_s3_n_i, cover_switch_i}),
    .q_o(misc_sync)
  );

  assign supply_good_s = misc_sync[2];
  assign sleep_s3_n_s = misc_sync[1];
  assign cover_s = misc_sync[0];

  assign wr_fw_flags = host_req_i.wr && (host_req_i.addr == rgei_pkg::OFS_FW_FLAGS);
  assign wr_fw_mask = host_req_i.wr && (host_req_i.addr == rgei_pkg::OFS_FW_MASK);
  assign wr_cover = host_req_i.wr && (host_req_i.addr == rgei_pkg::OFS_COVER);

  // octal pin number: upper octal digit in bits 5:3 and low three bits
  always_comb begin
    pin_valid = (pin_select_i != rgei_pkg::SEL_HOLE) && (pin_select_i <= rgei_pkg::SEL_LAST);
    pin_index = {pin_select_i[5:3], pin_select_i[2:0]};
  end

  // firmware flags: hardware set wins over host clear
  always_comb begin
    fw_flags_next = fw_flags_reg;
    if (wr_fw_flags && !ec_clear_block_i) begin
      fw_flags_next = fw_flags_next & ~host_req_i.wdata;
    end
    fw_flags_next = fw_flags_next | ec_fw_set_i;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fw_flags_reg <= rgei_pkg::FW_FLAGS_RST;
    end else begin
      fw_flags_reg <= fw_flags_next;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fw_mask_reg <= rgei_pkg::FW_MASK_RST;
    end else if (wr_fw_mask) begin
      fw_mask_reg <= host_req_i.wdata;
    end
  end

  assign fw_summary = |(fw_flags_reg & fw_mask_reg);

  // last supply state lives on battery reset only
  always_ff @(posedge core_clk_i or posedge battery_por_i) begin
    if (battery_por_i) begin
      supply_good_d_reg <= 1'b0;
      last_supply_state_reg <= rgei_pkg::LAST_SUPPLY_RST;
    end else begin
      supply_good_d_reg <= supply_good_s;
      if (supply_good_d_reg && !supply_good_s) begin
        last_supply_state_reg <= sleep_s3_n_s;
      end
    end
  end

  // cover latch on battery domain; armed avoids a false edge after reset
  always_ff @(posedge core_clk_i or posedge battery_por_i) begin
    if (battery_por_i) begin
      cover_d_reg <= 1'b0;
      cover_warm_reg <= 2'h0;
      cover_armed_reg <= 1'b0;
    end else begin
      cover_d_reg <= cover_s;
      // wait until the synchroniser and delay stage both hold the real pin level
      cover_warm_reg <= {cover_warm_reg[0], 1'b1};
      cover_armed_reg <= cover_warm_reg[1];
    end
  end

  assign cover_change = cover_armed_reg && (cover_d_reg != cover_s);

  always_ff @(posedge core_clk_i or posedge battery_por_i) begin
    if (battery_por_i) begin
      cover_event_reg <= rgei_pkg::COVER_EVENT_RST;
    end else if (cover_change) begin
      cover_event_reg <= 1'b1;
    end else if (wr_cover && host_req_i.wdata[rgei_pkg::COVER_EVENT_BIT]) begin
      cover_event_reg <= 1'b0;
    end
  end

  // intrusion status shadows the latch; set at standby reset if latched
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      intr_sts_reg <= 1'b0;
      intr_clr_pend_reg <= 1'b0;
    end else begin
      if (cover_change) begin
        intr_sts_reg <= 1'b1;
        intr_clr_pend_reg <= 1'b0;
      end else if (intr_clr_pend_reg && !cover_s) begin
        intr_sts_reg <= 1'b0;
        intr_clr_pend_reg <= 1'b0;
      end else if (wr_cover && host_req_i.wdata[rgei_pkg::COVER_EVENT_BIT] && intr_sts_reg) begin
        intr_clr_pend_reg <= 1'b1;
      end else if (cover_event_reg && !intr_sts_reg && !intr_clr_pend_reg && !wr_cover) begin
        intr_sts_reg <= 1'b1;
      end
    end
  end

  // event outputs: ungated fw summary level, plus intrusion status pulse on enable rising edge
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pme_en_d_reg <= 1'b0;
      smi_en_d_reg <= 1'b0;
      pme_event_o <= 1'b0;
      smi_event_o <= 1'b0;
      event_status_o <= '0;
    end else begin
      pme_en_d_reg <= pme_intr_en_i;
      smi_en_d_reg <= smi_intr_en_i;
      event_status_o.pme_fw_event <= fw_summary;
      event_status_o.smi_fw_event <= fw_summary;
      event_status_o.pme_intrusion <= intr_sts_reg;
      event_status_o.smi_intrusion <= intr_sts_reg;
      pme_event_o <= fw_summary || (intr_sts_reg && pme_intr_en_i && !pme_en_d_reg);
      smi_event_o <= fw_summary || (intr_sts_reg && smi_intr_en_i && !smi_en_d_reg);
    end
  end

  // host read data, registered
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      host_rdata_o <= 8'h00;
    end else if (host_req_i.rd) begin
      host_rdata_o <= 8'h00;
      case (host_req_i.addr)
        rgei_pkg::OFS_PIN_LEVEL: begin
          host_rdata_o[rgei_pkg::PIN_LEVEL_BIT] <= pin_valid && gpio_read_en_i[pin_index]
            && gpio_sync[pin_index];
        end
        rgei_pkg::OFS_FW_FLAGS: begin
          host_rdata_o <= fw_flags_reg;
        end
        rgei_pkg::OFS_FW_MASK: begin
          host_rdata_o <= fw_mask_reg;
        end
        rgei_pkg::OFS_PWR_LOSS: begin
          host_rdata_o[rgei_pkg::LAST_SUPPLY_BIT] <= last_supply_state_reg;
        end
        rgei_pkg::OFS_COVER: begin
          host_rdata_o[rgei_pkg::COVER_LEVEL_BIT] <= cover_s;
          host_rdata_o[rgei_pkg::COVER_EVENT_BIT] <= cover_event_reg;
        end
        default: begin
          host_rdata_o <= 8'h00;
        end
      endcase
    end
  end
endmodule // rgei_runtime_regs

// file: rgei_runtime_regs_asserts.sv
`timescale 1ns/1ps
module rgei_runtime_regs_asserts #(
  parameter int PIN_COUNT = rgei_pkg::PIN_SPACE
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // host port
  input wire rgei_pkg::rgei_host_req_t host_req_i,
  input wire logic [7:0] host_rdata_o,
  // events
  input wire logic pme_intr_en_i,
  input wire rgei_pkg::rgei_event_t event_status_o,
  input wire logic pme_event_o,
  input wire logic smi_event_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  a_fw_pair:
  assert property (event_status_o.pme_fw_event == event_status_o.smi_fw_event) else $error("fw summary split");
  a_fw_raise:
  assert property ($rose(event_status_o.pme_fw_event) |-> ##[0:1] (pme_event_o && smi_event_o))
    else $error("fw event not raised");
  a_intr_pair:
  assert property (event_status_o.pme_intrusion == event_status_o.smi_intrusion) else $error("intrusion split");
  a_pin_reserved:
  assert property (host_req_i.rd && host_req_i.addr == rgei_pkg::OFS_PIN_LEVEL |=> host_rdata_o[7:1] == 7'h00)
    else $error("pin port reserved bits set");
  a_supply_reserved:
  assert property (host_req_i.rd && host_req_i.addr == rgei_pkg::OFS_PWR_LOSS |=> host_rdata_o[6:0] == 7'h00)
    else $error("supply record reserved bits set");
  a_cover_reserved:
  assert property (host_req_i.rd && host_req_i.addr == rgei_pkg::OFS_COVER |=> host_rdata_o[7:2] == 6'h00)
    else $error("cover reserved bits set");
  a_mask_readback:
  assert property ((host_req_i.wr && host_req_i.addr == rgei_pkg::OFS_FW_MASK) ##2
    (host_req_i.rd && host_req_i.addr == rgei_pkg::OFS_FW_MASK) |=> host_rdata_o == $past(host_req_i.wdata, 3))
    else $error("mask readback wrong");
  a_intr_enable_rise:
  assert property ($rose(pme_intr_en_i) && event_status_o.pme_intrusion |-> ##[0:2] pme_event_o)
    else $error("no event on enable rise");
  cover property (host_req_i.wr && host_req_i.addr == rgei_pkg::OFS_COVER);
  cover property ($rose(event_status_o.pme_intrusion));
  cover property ($rose(event_status_o.pme_fw_event));
endmodule // rgei_runtime_regs_asserts
bind rgei_runtime_regs rgei_runtime_regs_asserts #(.PIN_COUNT(PIN_COUNT)) i_asserts (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .host_req_i(host_req_i), .host_rdata_o(host_rdata_o),
  .pme_intr_en_i(pme_intr_en_i), .event_status_o(event_status_o), .pme_event_o(pme_event_o),
  .smi_event_o(smi_event_o));

// file: rgei_host_model.sv
`timescale 1ns/1ps
module rgei_host_model (
  // clock
  input wire logic clk_i,
  // register port
  output rgei_pkg::rgei_host_req_t req_o,
  input wire logic [7:0] rdata_i
);
  initial req_o = '0;
  // idle cycle after each access keeps strobes from merging
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(posedge clk_i);
    req_o <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    req_o <= '0;
    #1 d = rdata_i;
  endtask
endmodule // rgei_host_model

// file: rgei_runtime_regs_tb.sv
`timescale 1ns/1ps
module rgei_runtime_regs_tb;
  logic clk, rst, bpor, blk, pg, s3_n, cov, pen, sen, pme, smi;
  logic [1:0] seen;
  logic [5:0] sel;
  logic [7:0] fws, rdata;
  logic [63:0] lvl, ren;
  rgei_pkg::rgei_host_req_t req;
  rgei_pkg::rgei_event_t ev;
  int err_count = 0;
  int n_checks = 0;
  int sels[8] = '{0, 7, 8, 30, 31, 57, 58, 63};
  rgei_runtime_regs i_dut (.core_clk_i(clk), .sys_rst_i(rst), .battery_por_i(bpor), .host_req_i(req),
    .host_rdata_o(rdata), .pin_select_i(sel), .ec_fw_set_i(fws), .ec_clear_block_i(blk), .gpio_level_i(lvl),
    .gpio_read_en_i(ren), .supply_good_in_i(pg), .sleep_s3_n_i(s3_n), .cover_switch_i(cov),
    .pme_intr_en_i(pen), .smi_intr_en_i(sen), .event_status_o(ev), .pme_event_o(pme), .smi_event_o(smi));
  rgei_host_model i_host (.clk_i(clk), .req_o(req), .rdata_i(rdata));
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_host.rd(a, d);
    chk8($sformatf("reg_%h", a), e, d);
  endtask
  task automatic fw_pulse(input logic [7:0] v);
    @(posedge clk) fws <= v;
    @(posedge clk) fws <= 8'h00;
    tick(3);
  endtask
  task automatic supply_fall(input logic s);
    @(posedge clk) {pg, s3_n} <= {1'h1, s};
    tick(4);
    @(posedge clk) pg <= 1'h0;
    tick(5);
  endtask
  task automatic final_report;
    if (err_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    {rst, bpor, blk, pg, s3_n, cov, pen, sen} = 8'hC0;
    {sel, fws, lvl, ren} = {6'h00, 8'h00, 64'hFE00_0000_8000_0181, {64{1'h1}}};
    repeat (20) @(posedge clk);
    {rst, bpor} <= 2'h0;
    tick(4);
    rchk(8'h34, 8'h01);
    rchk(8'h30, 8'h00);
    rchk(8'h31, 8'h00);
    rchk(8'h32, 8'h00);
    rchk(8'h33, 8'h00);
    i_host.wr(8'h34, 8'h01);
    tick(4);
    rchk(8'h34, 8'h00);
    chk8("intr", 8'h00, {7'h00, ev.pme_intrusion});
    @(posedge clk) cov <= 1'h1;
    tick(6);
    rchk(8'h34, 8'h03);
    chk8("intr", 8'h01, {7'h00, ev.smi_intrusion});
    i_host.wr(8'h34, 8'h01);
    tick(4);
    rchk(8'h34, 8'h02);
    chk8("intr", 8'h01, {7'h00, ev.pme_intrusion});
    @(posedge clk) {pen, sen} <= 2'h3;
    seen = 2'h0;
    repeat (4) begin
      tick(1);
      seen |= {pme, smi};
    end
    chk8("en_rise", 8'h03, {6'h00, seen});
    @(posedge clk) cov <= 1'h0;
    tick(6);
    rchk(8'h34, 8'h01);
    i_host.wr(8'h34, 8'h00);
    rchk(8'h34, 8'h01);
    i_host.wr(8'h34, 8'h01);
    tick(4);
    chk8("intr", 8'h00, {7'h00, ev.pme_intrusion});
    i_host.wr(8'h31, 8'h81);
    rchk(8'h31, 8'h81);
    fw_pulse(8'h02);
    chk8("fwe", 8'h00, {6'h00, ev.pme_fw_event, ev.smi_fw_event});
    fw_pulse(8'h01);
    chk8("fwe", 8'h03, {6'h00, ev.pme_fw_event, ev.smi_fw_event});
    @(posedge clk) blk <= 1'h1;
    i_host.wr(8'h30, 8'hFF);
    rchk(8'h30, 8'h03);
    @(posedge clk) blk <= 1'h0;
    i_host.wr(8'h30, 8'h01);
    rchk(8'h30, 8'h02);
    chk8("fwe", 8'h00, {6'h00, ev.pme_fw_event, ev.smi_fw_event});
    // system reset mid-run must leave the battery-side latch alone
    @(posedge clk) cov <= 1'h1;
    tick(6);
    @(posedge clk) rst <= 1'h1;
    @(posedge clk) rst <= 1'h0;
    tick(4);
    rchk(8'h34, 8'h03);
    rchk(8'h31, 8'h00);
    rchk(8'h30, 8'h00);
    supply_fall(1'h1);
    rchk(8'h32, 8'h80);
    supply_fall(1'h0);
    rchk(8'h32, 8'h00);
    foreach (sels[k]) begin
      @(posedge clk) sel <= 6'(sels[k]);
      tick(4);
      rchk(8'h29, (sels[k] <= 57 && sels[k] != 31) ? {7'h00, lvl[sels[k]]} : 8'h00);
    end
    @(posedge clk) {sel, ren[0]} <= 7'h00;
    tick(4);
    rchk(8'h29, 8'h00);
    final_report;
  end
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    final_report;
  end
endmodule // rgei_runtime_regs_tb
